// >>> core/bcte_core.sv
// bus cycle timer, cycle events and wishbone register file
//
// Contract
// R1: bad transaction code sets its status bit
// R2: cycle over 125us flags overrun, drops master
// R3: seconds increment sets second tick flag
// R4: sent or received cycle start sets flag
// R5: fair gap after cycle start sets end
// R6: writing zero leaves cycle end bit
// R7: pending from offset zero until cycle ends
// R8: two rollovers without start, non-master: missed
// R9: enable register mirrors status bit layout
// R10: disabled events still update status bits
// R11: enable bits 21 down to 0 exist
// R12: timer runs only with run bit set
// R13: seconds field bits 31..25 at 1 Hz
// R14: cycle number bits 24..12 at 8 kHz
// R15: offset bits 11..0 at 24.576 MHz
// R16: writing one clears a status bit
// R17: interrupt low while enabled status set
// R18: offset wraps 3071, number wraps 7999
`timescale 1ns/1ps
module bcte_core
	import bcte_pkg::*;
#(
	parameter int CYC_LIMIT = BCTE_CYC_LIMIT_CYC  // overrun limit in clock cycles
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        cs_tx_pulse,
	input  wire logic        cs_rx_pulse,
	input  wire logic        fair_gap_pulse,
	input  wire logic        bad_txn_code_pulse,
	output logic             int_n,
	output logic             cycle_master_out
);

	////////////////////////////////////////////////////////////////////////
	// reset synchroniser

	logic        rst_meta_reg;   // first stage, read only by second
	logic        rst_n_reg;      // released reset used by the design

	// release reset through two flops
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state declarations

	logic [31:0]               cyc_time_reg;   // seconds / number / offset
	logic [BCTE_EN_BITS-1:0]   evt_en_reg;     // event enables
	logic [BCTE_EVT_BITS-1:0]  evt_stat_reg;   // sticky events
	logic                      run_reg;        // timer run control
	logic                      master_reg;     // cycle master control
	bcte_phase_e               phase_reg;      // inside an isochronous cycle
	logic                      pend_reg;       // cycle pending level
	logic [1:0]                roll_cnt_reg;   // rollovers since rx start
	logic [16:0]               frac_reg;       // offset tick accumulator
	logic [15:0]               ovr_cnt_reg;    // cycle length counter
	logic                      ack_reg;        // bus acknowledge
	logic [31:0]               dat_reg;        // bus read data
	logic                      int_n_reg;      // interrupt output flop

	////////////////////////////////////////////////////////////////////////
	// bus decode

	wire        bus_req    = wb_cyc_i & wb_stb_i;
	wire        wr_now     = bus_req & wb_we_i & ack_reg;   // write lands at ack edge
	wire [31:0] byte_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wr_bits    = wb_dat_i & byte_mask;
	wire        hit_ctl    = (wb_adr_i[7:2] == BCTE_ADR_LINK_CTL[7:2]);
	wire        hit_stat   = (wb_adr_i[7:2] == BCTE_ADR_EVT_STAT[7:2]);
	wire        hit_en     = (wb_adr_i[7:2] == BCTE_ADR_EVT_EN[7:2]);
	wire        hit_time   = (wb_adr_i[7:2] == BCTE_ADR_CYC_TIME[7:2]);
	wire        wr_ctl     = wr_now & hit_ctl;
	wire        wr_stat    = wr_now & hit_stat;
	wire        wr_en      = wr_now & hit_en;
	wire        wr_time    = wr_now & hit_time;

	////////////////////////////////////////////////////////////////////////
	// cycle timer fields and wraps

	wire [11:0] off_f      = cyc_time_reg[BCTE_OFF_MSB:BCTE_OFF_LSB];
	wire [12:0] num_f      = cyc_time_reg[BCTE_NUM_MSB:BCTE_NUM_LSB];
	wire [6:0]  sec_f      = cyc_time_reg[BCTE_SEC_MSB:BCTE_SEC_LSB];
	wire [16:0] frac_sum   = frac_reg + 17'(BCTE_OFF_KHZ);
	wire        off_tick   = run_reg & (frac_sum >= 17'(BCTE_CLK_KHZ)); // R12 R15
	wire        off_wrap   = off_tick & (off_f == BCTE_OFF_LAST);       // R18
	wire        num_wrap   = off_wrap & (num_f == BCTE_NUM_LAST);       // R18
	wire [11:0] off_next   = off_wrap ? 12'h000 : off_f + 12'h001;      // R15
	wire [12:0] num_next   = num_wrap ? 13'h0000 : num_f + 13'h0001;    // R14
	wire [6:0]  sec_next   = sec_f + 7'h01;                             // R13
	wire [31:0] time_run   = {num_wrap ? sec_next : sec_f,
	                          off_wrap ? num_next : num_f,
	                          off_next};
	wire [31:0] time_wr    = (cyc_time_reg & ~byte_mask) | wr_bits;
	wire [31:0] time_next  = wr_time ? time_wr :                        // R12
	                         off_tick ? time_run : cyc_time_reg;
	wire        off_zeroed = (time_next[BCTE_OFF_MSB:BCTE_OFF_LSB] == 12'h000)
	                         & (off_wrap | wr_time);                    // R7

	////////////////////////////////////////////////////////////////////////
	// cycle events

	wire        cs_any     = cs_tx_pulse | cs_rx_pulse;                  // R4
	wire        in_cycle   = (phase_reg == BCTE_PH_CYCLE);
	wire        cyc_end    = in_cycle & fair_gap_pulse;                  // R5
	wire        overrun    = in_cycle & ~fair_gap_pulse
	                         & (ovr_cnt_reg >= 16'(CYC_LIMIT));          // R2
	wire        lost       = ~master_reg & off_wrap & ~cs_rx_pulse
	                         & (roll_cnt_reg == BCTE_LOST_ROLLS - 2'h1); // R8

	// hardware event set vector
	wire [BCTE_EVT_BITS-1:0] evt_set;
	assign evt_set[BCTE_BIT_TXN]   = bad_txn_code_pulse;                 // R1
	assign evt_set[BCTE_BIT_OVER]  = overrun;                            // R2
	assign evt_set[BCTE_BIT_SEC]   = num_wrap;                           // R3
	assign evt_set[BCTE_BIT_BEGIN] = cs_any;                             // R4
	assign evt_set[BCTE_BIT_END]   = cyc_end;                            // R5
	assign evt_set[BCTE_BIT_PEND]  = 1'b0;
	assign evt_set[BCTE_BIT_LOST]  = lost;                               // R8

	// write-one clear, zeros leave bits alone, set beats clear
	wire [BCTE_EVT_BITS-1:0] evt_clr = wr_stat ? wr_bits[BCTE_EVT_BITS-1:0]
	                                           : '0;                     // R6 R16
	wire [BCTE_EVT_BITS-1:0] stat_next = (evt_stat_reg & ~evt_clr) | evt_set;

	// status as read: pending bit is the live level
	wire [BCTE_EVT_BITS-1:0] stat_view;
	assign stat_view = {evt_stat_reg[BCTE_EVT_BITS-1:BCTE_BIT_PEND+1],
	                    pend_reg, evt_stat_reg[BCTE_BIT_LOST]};

	// enabled events raise the interrupt, masked ones only report
	wire irq_any = |(stat_view & evt_en_reg[BCTE_EVT_BITS-1:0]);         // R9 R10 R17

	////////////////////////////////////////////////////////////////////////
	// read mux

	wire [31:0] rd_mux = hit_ctl  ? {30'h0, master_reg, run_reg} :
	                     hit_stat ? {25'h0, stat_view} :
	                     hit_en   ? {10'h0, evt_en_reg} :                // R11
	                     hit_time ? cyc_time_reg : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after request, dropped next cycle

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end
		else if (clk_en)
		begin
			ack_reg <= bus_req & ~ack_reg;
			dat_reg <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and enable registers

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			run_reg    <= BCTE_RST_LINK_CTL[BCTE_BIT_RUN];
			master_reg <= BCTE_RST_LINK_CTL[BCTE_BIT_MASTER];
			evt_en_reg <= BCTE_RST_EVT_EN[BCTE_EN_BITS-1:0];
		end
		else if (clk_en)
		begin
			// software control of run and master
			if (wr_ctl & wb_sel_i[0])
			begin
				run_reg    <= wb_dat_i[BCTE_BIT_RUN];
				master_reg <= wb_dat_i[BCTE_BIT_MASTER];
			end
			// overrun takes the master role away
			if (overrun)
				master_reg <= 1'b0;                                      // R2
			// enable bits keep the status layout
			if (wr_en)
				evt_en_reg <= (evt_en_reg & ~byte_mask[BCTE_EN_BITS-1:0])
				              | wr_bits[BCTE_EN_BITS-1:0];               // R9 R11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cycle timer and tick accumulator

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			cyc_time_reg <= BCTE_RST_CYC_TIME;
			frac_reg     <= 17'h00000;
		end
		else if (clk_en)
		begin
			cyc_time_reg <= time_next;                                   // R12
			if (!run_reg)
				frac_reg <= 17'h00000;
			else if (off_tick)
				frac_reg <= frac_sum - 17'(BCTE_CLK_KHZ);                // R15
			else
				frac_reg <= frac_sum;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cycle phase, pending, overrun and missed-start tracking

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			phase_reg    <= BCTE_PH_IDLE;
			pend_reg     <= 1'b0;
			ovr_cnt_reg  <= 16'h0000;
			roll_cnt_reg <= 2'h0;
		end
		else if (clk_en)
		begin
			// phase follows cycle start and fair gap
			case (phase_reg)
				BCTE_PH_IDLE:
				begin
					if (cs_any)
						phase_reg <= BCTE_PH_CYCLE;
				end
				BCTE_PH_CYCLE:
				begin
					if (fair_gap_pulse | overrun)
						phase_reg <= BCTE_PH_IDLE;
				end
				default:
					phase_reg <= BCTE_PH_IDLE;
			endcase
			// pending: set at offset zero, held until cycle ends
			if (off_zeroed)
				pend_reg <= 1'b1;                                        // R7
			else if (cyc_end)
				pend_reg <= 1'b0;                                        // R7
			// cycle length counter
			if (cs_any | ~in_cycle)
				ovr_cnt_reg <= 16'h0000;
			else if (ovr_cnt_reg != 16'hFFFF)
				ovr_cnt_reg <= ovr_cnt_reg + 16'h0001;                   // R2
			// rollovers seen since the last received start
			if (cs_rx_pulse | master_reg | lost)
				roll_cnt_reg <= 2'h0;                                    // R8
			else if (off_wrap)
				roll_cnt_reg <= roll_cnt_reg + 2'h1;                     // R8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status and interrupt output

	always_ff @(posedge clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			evt_stat_reg <= '0;
			int_n_reg    <= 1'b1;
		end
		else if (clk_en)
		begin
			evt_stat_reg <= stat_next;                                   // R10 R16
			int_n_reg    <= ~irq_any;                                    // R17
		end
	end

	// outputs straight from flops
	assign wb_ack_o         = ack_reg;
	assign wb_dat_o         = dat_reg;
	assign int_n            = int_n_reg;
	assign cycle_master_out = master_reg;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_reg);

	// bad transaction code is caught
	property p_txn_err;
		clk_en && bad_txn_code_pulse |=> evt_stat_reg[BCTE_BIT_TXN];
	endproperty
	a_txn_err: assert property (p_txn_err) else $error("txn code flag missed"); // R1

	// overrun flags and drops master
	property p_overrun;
		clk_en && overrun |=> evt_stat_reg[BCTE_BIT_OVER] && !master_reg;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled"); // R2

	// second wrap raises the tick flag and bumps seconds
	property p_second;
		clk_en && num_wrap |=> evt_stat_reg[BCTE_BIT_SEC]
		&& (cyc_time_reg[31:25] == $past(sec_f) + 7'h01 || $past(wr_time));
	endproperty
	a_second: assert property (p_second) else $error("second tick wrong"); // R3 R13

	// cycle start sets begin flag, then a gap sets end flag
	property p_begin_end;
		clk_en && cs_any ##1 (clk_en && fair_gap_pulse && !cs_any)
		|=> evt_stat_reg[BCTE_BIT_BEGIN] && evt_stat_reg[BCTE_BIT_END];
	endproperty
	a_begin_end: assert property (p_begin_end) else $error("cycle flags wrong"); // R4 R5

	// writing zero keeps the end flag
	property p_end_keep;
		clk_en && wr_stat && !wr_bits[BCTE_BIT_END] && evt_stat_reg[BCTE_BIT_END]
		|=> evt_stat_reg[BCTE_BIT_END];
	endproperty
	a_end_keep: assert property (p_end_keep) else $error("end flag lost"); // R6

	// writing one clears unless an event arrives
	property p_w1c;
		clk_en && wr_stat && wr_bits[BCTE_BIT_TXN] && !bad_txn_code_pulse
		|=> !evt_stat_reg[BCTE_BIT_TXN];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear"); // R16

	// offset rollover sets pending and brings the offset back to zero
	property p_pending;
		clk_en && off_wrap && !wr_time |=> pend_reg && off_f == 12'h000;
	endproperty
	a_pending: assert property (p_pending) else $error("pending or wrap wrong"); // R7 R18

	// two rollovers without a start give a missed cycle
	property p_lost;
		clk_en && lost |=> evt_stat_reg[BCTE_BIT_LOST] && roll_cnt_reg == 2'h0;
	endproperty
	a_lost: assert property (p_lost) else $error("missed cycle not flagged"); // R8

	// stopped timer holds unless written
	property p_hold;
		clk_en && !run_reg && !wr_time |=> $stable(cyc_time_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("stopped timer moved"); // R12

	// interrupt follows enabled status one cycle later
	property p_irq;
		clk_en |=> int_n == !($past(irq_any));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong"); // R10 R17

	// number counter steps by one on an offset wrap
	property p_number;
		clk_en && off_wrap && !num_wrap && !wr_time
		|=> cyc_time_reg[24:12] == $past(num_f) + 13'h0001;
	endproperty
	a_number: assert property (p_number) else $error("number step wrong"); // R14

endmodule // bcte_core

// >>> pkg/bcte_pkg.sv
// constants shared by the bus cycle timer and event block
package bcte_pkg;

	// register byte offsets on the wishbone bus
	localparam logic [7:0]  BCTE_ADR_LINK_CTL  = 8'h04;
	localparam logic [7:0]  BCTE_ADR_EVT_STAT  = 8'h08;
	localparam logic [7:0]  BCTE_ADR_EVT_EN    = 8'h0C;
	localparam logic [7:0]  BCTE_ADR_CYC_TIME  = 8'h10;

	// event status / enable bit positions
	localparam int          BCTE_BIT_LOST      = 0;
	localparam int          BCTE_BIT_PEND      = 1;
	localparam int          BCTE_BIT_END       = 2;
	localparam int          BCTE_BIT_BEGIN     = 3;
	localparam int          BCTE_BIT_SEC       = 4;
	localparam int          BCTE_BIT_OVER      = 5;
	localparam int          BCTE_BIT_TXN       = 6;
	localparam int          BCTE_EVT_BITS      = 7;
	localparam int          BCTE_EN_BITS       = 22;

	// link control bit positions
	localparam int          BCTE_BIT_RUN       = 0;
	localparam int          BCTE_BIT_MASTER    = 1;

	// cycle time field positions
	localparam int          BCTE_SEC_MSB       = 31;
	localparam int          BCTE_SEC_LSB       = 25;
	localparam int          BCTE_NUM_MSB       = 24;
	localparam int          BCTE_NUM_LSB       = 12;
	localparam int          BCTE_OFF_MSB       = 11;
	localparam int          BCTE_OFF_LSB       = 0;

	// reset values
	localparam logic [31:0] BCTE_RST_EVT_EN    = 32'h00000000;
	localparam logic [31:0] BCTE_RST_CYC_TIME  = 32'h00000000;
	localparam logic [1:0]  BCTE_RST_LINK_CTL  = 2'h0;

	// counter wrap points
	localparam logic [11:0] BCTE_OFF_LAST      = 12'hBFF;   // 3071
	localparam logic [12:0] BCTE_NUM_LAST      = 13'h1F3F;  // 7999

	// offset tick: 24.576 MHz made from the system clock by a fraction
	localparam int          BCTE_CLK_KHZ       = 100000;
	localparam int          BCTE_OFF_KHZ       = 24576;

	// cycle overrun limit
	localparam int          BCTE_CLK_PERIOD_NS = 10;
	localparam int          BCTE_CYC_LIMIT_NS  = 125000;
	localparam int          BCTE_CYC_LIMIT_CYC = BCTE_CYC_LIMIT_NS / BCTE_CLK_PERIOD_NS;

	// rollovers without a received cycle start before a miss
	localparam logic [1:0]  BCTE_LOST_ROLLS    = 2'h2;

	// phase of the isochronous cycle
	typedef enum logic {BCTE_PH_IDLE, BCTE_PH_CYCLE} bcte_phase_e;

endpackage

// >>> verification/bcte_phy_model.sv
// serial bus side model: emits cycle start, fair gap and bad code pulses
`timescale 1ns/1ps
module bcte_phy_model
(
	input  wire logic       clk,
	input  wire logic [3:0] req,                // 0 bad code, 1 tx start, 2 rx start, 3 gap
	output logic            cs_tx_pulse,
	output logic            cs_rx_pulse,
	output logic            fair_gap_pulse,
	output logic            bad_txn_code_pulse
);
	logic [3:0] job_reg  = 4'h0;                // captured request
	logic [1:0] step_reg = 2'h0;                // 0 idle, 1 start, 2 gap, 3 bad code
	//////////////////////////////////////////////////////////////////////////
	// start first, then the gap, then the bad code: a gap never leads a start
	always_ff @(posedge clk)
	begin
		if (step_reg == 2'h0)
		begin
			job_reg  <= req;
			step_reg <= (req != 4'h0) ? 2'h1 : 2'h0;
		end
		else
			step_reg <= step_reg + 2'h1;    // wraps back to idle
	end
	// each pulse lasts exactly one clock
	assign cs_tx_pulse        = (step_reg == 2'h1) & job_reg[1];
	assign cs_rx_pulse        = (step_reg == 2'h1) & job_reg[2];
	assign fair_gap_pulse     = (step_reg == 2'h2) & job_reg[3];
	assign bad_txn_code_pulse = (step_reg == 2'h3) & job_reg[0];
endmodule // bcte_phy_model

// >>> verification/bcte_core_bench.sv
// self-checking bench for the cycle timer and event block
`timescale 1ns/1ps
module bcte_core_bench
	import bcte_pkg::*;
;
	logic        clk, nrst, cyc, stb, we;   // clock, reset and bus strobes
	logic [7:0]  adr;                       // bus address
	logic [3:0]  sel, req;                  // byte lanes, model request
	logic [31:0] dat, rdat, q;              // write data, read data, read result
	logic        ack, int_n, mst;           // design outputs
	logic        tx, rx, gap, bad;          // event pulses
	int          err_count, n_tests, cyc_cnt;
	logic [3:0]  row_req [4] = '{4'h1, 4'hA, 4'hC, 4'h8};
	logic [31:0] row_exp [4] = '{32'h40, 32'h0C, 32'h0C, 32'h00};
	bcte_core #(.CYC_LIMIT(40)) u_dut (.clk(clk), .nrst(nrst), .clk_en(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cs_tx_pulse(tx), .cs_rx_pulse(rx), .fair_gap_pulse(gap),
		.bad_txn_code_pulse(bad), .int_n(int_n), .cycle_master_out(mst));
	bcte_phy_model u_phy (.clk(clk), .req(req), .cs_tx_pulse(tx),
		.cs_rx_pulse(rx), .fair_gap_pulse(gap), .bad_txn_code_pulse(bad));
	//////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 40000)
		begin
			err_count = err_count + 1;
			results();
		end
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one classic cycle: hold everything until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n = n + 1;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		if (n == 20)
			chk("ack", 32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string what);
		xfer(1'b0, a, 32'h0);
		chk(what, e, q & m);
	endtask
	task automatic send(input logic [3:0] r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= 4'h0;
		repeat (6) @(posedge clk);
	endtask
	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		err_count = 0;
		n_tests = 0;
		cyc_cnt = 0;
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0;
		req = 4'h0;
		nrst = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("int_n reset", 32'h1, {31'h0, int_n});
		rd(BCTE_ADR_EVT_EN, 32'hFFFFFFFF, 32'h0, "enable reset");
		rd(BCTE_ADR_CYC_TIME, 32'hFFFFFFFF, 32'h0, "time reset");
		xfer(1'b1, BCTE_ADR_EVT_EN, 32'h0000006C);
		// ordinary event rows: pulse, read status, check interrupt, clear
		for (int i = 0; i < 4; i++)
		begin
			send(row_req[i]);
			rd(BCTE_ADR_EVT_STAT, 32'h6C, row_exp[i], "status row");
			chk("int_n row", {31'h0, row_exp[i] == 0}, {31'h0, int_n});
			xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h7F);
			rd(BCTE_ADR_EVT_STAT, 32'h6C, 32'h0, "status cleared");
			chk("int_n clear", 32'h1, {31'h0, int_n});
		end
		// overrun: master sends a start and no gap follows
		xfer(1'b1, BCTE_ADR_LINK_CTL, 32'h2);
		// the control write lands at the ack edge, so look one edge later
		@(posedge clk);
		chk("master on", 32'h1, {31'h0, mst});
		send(4'h2);
		repeat (60) @(posedge clk);
		rd(BCTE_ADR_EVT_STAT, 32'h6C, 32'h28, "overrun");
		chk("master off", 32'h0, {31'h0, mst});
		xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h7F);
		// a zero written to the end bit keeps it
		send(4'hA);
		xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h0);
		rd(BCTE_ADR_EVT_STAT, 32'h04, 32'h04, "end kept");
		xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h7F);
		// masked event still shows in status
		xfer(1'b1, BCTE_ADR_EVT_EN, 32'h0);
		send(4'h1);
		rd(BCTE_ADR_EVT_STAT, 32'h40, 32'h40, "masked status");
		chk("int_n masked", 32'h1, {31'h0, int_n});
		xfer(1'b1, BCTE_ADR_EVT_EN, 32'h40);
		rd(BCTE_ADR_EVT_EN, 32'hFFFFFFFF, 32'h40, "enable read");
		chk("int_n unmasked", 32'h0, {31'h0, int_n});
		xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h7F);
		xfer(1'b1, BCTE_ADR_EVT_EN, 32'hFFFFFFFF);
		rd(BCTE_ADR_EVT_EN, 32'hFFFFFFFF, 32'h003FFFFF, "enable width");
		xfer(1'b1, BCTE_ADR_EVT_EN, 32'h0);
		// unmapped address reads zero
		xfer(1'b1, 8'h20, 32'hFFFFFFFF);
		rd(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
		// stopped timer is plain storage
		xfer(1'b1, BCTE_ADR_LINK_CTL, 32'h0);
		xfer(1'b1, BCTE_ADR_CYC_TIME, 32'h12345678);
		repeat (20) @(posedge clk);
		rd(BCTE_ADR_CYC_TIME, 32'hFFFFFFFF, 32'h12345678, "stopped time");
		// both wraps at once: seconds 5 to 6, number and offset to zero
		xfer(1'b1, BCTE_ADR_CYC_TIME, {7'h05, 13'h1F3F, 12'hBFF});
		xfer(1'b1, BCTE_ADR_LINK_CTL, 32'h1);
		repeat (12) @(posedge clk);
		rd(BCTE_ADR_CYC_TIME, 32'hFFFFF000, {7'h06, 25'h0}, "wrap");
		rd(BCTE_ADR_EVT_STAT, 32'h12, 32'h12, "tick pending");
		xfer(1'b1, BCTE_ADR_EVT_STAT, 32'h7F);
		// two rollovers with no received start while not master
		repeat (26000) @(posedge clk);
		rd(BCTE_ADR_EVT_STAT, 32'h01, 32'h01, "missed");
		results();
	end
endmodule // bcte_core_bench
